// [core/dsr_cfg_bank.sv]
// configuration bank: i2c clock periods, datapath and display timing
`include "dsr_defines.svh"

module dsr_cfg_bank
   import dsr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data_ff,
   // forward channel configuration load
   input wire logic i_fc_load,
   input wire logic [7:0] i_fc_cfg,
   // link status and receiver mode
   input wire logic i_link_up,
   input wire logic i_lock_mode,
   input wire logic [1:0] i_input_mode,
   output logic o_rx_lock_ff,
   output logic o_rx_dual_ff,
   // local i2c master clock, open drain
   input wire logic i_mst_run,
   input wire logic i_mst_scl_pin,
   output logic o_mst_scl_o_ff,
   output logic o_mst_scl_oe_ff,
   output logic o_mst_scl_seen_ff,
   // i2c slave clock stretch
   input wire logic i_slv_stretch_req,
   input wire logic i_slv_data_presented,
   output logic o_slv_scl_o_ff,
   output logic o_slv_scl_oe_ff,
   // datapath and display controls
   output dsr_dp_cfg_t o_dp_cfg_ff,
   input wire dsr_sync_t i_sync,
   output dsr_sync_t o_sync_ff,
   output dsr_dither_t o_dither_ff,
   output logic o_audio_out_en_ff,
   output logic o_surround_en_ff,
   output logic o_gpio1_word_clk_sel_ff,
   output logic o_gpio0_audio_data_sel_ff,
   output logic o_ctl_chan_en_ff
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic [7:0] scl_high_ff;
   logic [7:0] scl_low_ff;
   logic [7:0] datapath_ff;
   logic [7:0] display_ff;
   logic [7:0] nxt_datapath;
   logic [7:0] nxt_rd_data;
   logic [6:0] step_acc_ff;
   logic [6:0] nxt_step_acc;
   logic step_tick;
   logic scl_low;
   logic slv_hold;
   logic scl_pin_meta_ff;
   logic scl_pin_sync_ff;
   logic fc_take;

   // ***************************************************************
   // address decode
   // ***************************************************************

   // true when a write strobe hits the given offset
   function automatic logic hit_wr(input logic [7:0] ofs);
      hit_wr = i_wr_en && (i_addr == ofs);
   endfunction

   // ***************************************************************
   // step timebase
   // ***************************************************************

   // the period fields count 50ns steps but the clock is 40ns, so an
   // accumulator spreads the remainder; each step is one or two cycles
   // and the average is exact, which is what the bus timing cares about
   always_comb begin
      nxt_step_acc = step_acc_ff + `DSR_CLK_NS;
      step_tick = 1'b0;
      if (nxt_step_acc >= `DSR_STEP_NS) begin
         nxt_step_acc = nxt_step_acc - `DSR_STEP_NS;
         step_tick = 1'b1;
      end
   end

   // timebase register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         step_acc_ff <= 7'h00;
      end else begin
         step_acc_ff <= nxt_step_acc;
      end
   end

   // ***************************************************************
   // clock period registers
   // ***************************************************************

   // high phase length of the master clock
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         scl_high_ff <= `DSR_RST_SCL_HIGH;
      end else if (hit_wr(`DSR_OFS_SCL_HIGH)) begin
         scl_high_ff <= i_wr_data;
      end
   end

   // low phase length, shared with the slave setup wait
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         scl_low_ff <= `DSR_RST_SCL_LOW;
      end else if (hit_wr(`DSR_OFS_SCL_LOW)) begin
         scl_low_ff <= i_wr_data;
      end
   end

   // ***************************************************************
   // datapath register
   // ***************************************************************

   // forward channel may load only while local settings are not kept
   assign fc_take = i_fc_load && !datapath_ff[`DSR_DP_KEEP_LOCAL];

   // a forward load in the same cycle as a local write wins for the
   // fields it carries, since it reports link state; the override bit
   // itself is local only so the channel can never unlock itself
   always_comb begin
      nxt_datapath = datapath_ff;
      if (hit_wr(`DSR_OFS_DATAPATH)) begin
         nxt_datapath = i_wr_data;
      end
      if (fc_take) begin
         nxt_datapath[5:0] = i_fc_cfg[5:0];
      end
      nxt_datapath[`DSR_DP_RSVD] = 1'b0; // reserved bit reads zero
   end

   // holds whichever source wrote last
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         datapath_ff <= `DSR_RST_DATAPATH;
      end else begin
         datapath_ff <= nxt_datapath;
      end
   end

   // ***************************************************************
   // display timing and dither register
   // ***************************************************************

   // plain read/write controls
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         display_ff <= `DSR_RST_DISPLAY;
      end else if (hit_wr(`DSR_OFS_DISPLAY)) begin
         display_ff <= i_wr_data;
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************

   // unmapped offsets read as zero
   always_comb begin
      unique case (i_addr)
         `DSR_OFS_SCL_HIGH: nxt_rd_data = scl_high_ff;
         `DSR_OFS_SCL_LOW: nxt_rd_data = scl_low_ff;
         `DSR_OFS_DATAPATH: nxt_rd_data = datapath_ff;
         `DSR_OFS_DISPLAY: nxt_rd_data = display_ff;
         default: nxt_rd_data = 8'h00;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rd_data_ff <= 8'h00;
      end else if (i_rd_en) begin
         o_rd_data_ff <= nxt_rd_data;
      end else begin
         o_rd_data_ff <= 8'h00;
      end
   end

   // ***************************************************************
   // link status
   // ***************************************************************

   // lock mode 0 needs active video; mode 1 only needs a link
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rx_lock_ff <= 1'b0;
      end else begin
         o_rx_lock_ff <= i_link_up &&
            (i_lock_mode || !datapath_ff[`DSR_DP_VIDEO_OFF]);
      end
   end

   // forced modes ignore the reported link width
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rx_dual_ff <= 1'b0;
      end else if (i_input_mode == `DSR_MODE_AUTO) begin
         o_rx_dual_ff <= datapath_ff[`DSR_DP_DUAL_LINK];
      end else begin
         o_rx_dual_ff <= (i_input_mode == `DSR_MODE_DUAL);
      end
   end

   // control channel and gpio keep running with video off
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_ctl_chan_en_ff <= 1'b0;
      end else begin
         o_ctl_chan_en_ff <= i_link_up;
      end
   end

   // ***************************************************************
   // local i2c master clock
   // ***************************************************************

   // phase generator
   dsr_scl_gen u_scl_gen (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_run(i_mst_run),
      .i_step(step_tick),
      .i_high_steps(scl_high_ff),
      .i_low_steps(scl_low_ff),
      .o_scl_low_ff(scl_low)
   );

   // open drain: drive zero while low, release for the high phase
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_mst_scl_o_ff <= 1'b0;
         o_mst_scl_oe_ff <= 1'b0;
      end else begin
         o_mst_scl_o_ff <= 1'b0;
         o_mst_scl_oe_ff <= scl_low;
      end
   end

   // the pin is asynchronous; a slave may hold it, so it is watched
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         scl_pin_meta_ff <= 1'b1;
         scl_pin_sync_ff <= 1'b1;
         o_mst_scl_seen_ff <= 1'b1;
      end else begin
         scl_pin_meta_ff <= i_mst_scl_pin;
         scl_pin_sync_ff <= scl_pin_meta_ff;
         o_mst_scl_seen_ff <= scl_pin_sync_ff;
      end
   end

   // ***************************************************************
   // i2c slave clock stretch
   // ***************************************************************

   // setup wait after data goes onto the data line
   dsr_setup_wait u_setup_wait (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_data_presented(i_slv_data_presented),
      .i_step(step_tick),
      .i_low_steps(scl_low_ff),
      .o_hold_ff(slv_hold)
   );

   // clock held low while the slave waits for data or for setup
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_slv_scl_o_ff <= 1'b0;
         o_slv_scl_oe_ff <= 1'b0;
      end else begin
         o_slv_scl_o_ff <= 1'b0;
         o_slv_scl_oe_ff <= i_slv_stretch_req || slv_hold;
      end
   end

   // ***************************************************************
   // datapath controls
   // ***************************************************************

   // decoded view of the datapath register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_dp_cfg_ff <= '0;
      end else begin
         o_dp_cfg_ff.keep_local_datapath_settings <= datapath_ff[`DSR_DP_KEEP_LOCAL];
         o_dp_cfg_ff.video_off <= datapath_ff[`DSR_DP_VIDEO_OFF];
         o_dp_cfg_ff.dual_link <= datapath_ff[`DSR_DP_DUAL_LINK];
         o_dp_cfg_ff.audio_on_gpio <= datapath_ff[`DSR_DP_ALT_AUDIO];
         o_dp_cfg_ff.audio_on <= !datapath_ff[`DSR_DP_AUDIO_OFF];
         o_dp_cfg_ff.video_28bit <= datapath_ff[`DSR_DP_VIDEO_28];
         o_dp_cfg_ff.surround_on <= datapath_ff[`DSR_DP_SURROUND];
      end
   end

   // audio enables; surround is an audio mode so audio-off gates it too
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_audio_out_en_ff <= 1'b0;
         o_surround_en_ff <= 1'b0;
      end else begin
         o_audio_out_en_ff <= !datapath_ff[`DSR_DP_AUDIO_OFF];
         o_surround_en_ff <= datapath_ff[`DSR_DP_SURROUND] &&
            !datapath_ff[`DSR_DP_AUDIO_OFF];
      end
   end

   // alternate audio is an extra copy on the general pins
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_gpio1_word_clk_sel_ff <= 1'b0;
         o_gpio0_audio_data_sel_ff <= 1'b0;
      end else begin
         o_gpio1_word_clk_sel_ff <= datapath_ff[`DSR_DP_ALT_AUDIO];
         o_gpio0_audio_data_sel_ff <= datapath_ff[`DSR_DP_ALT_AUDIO];
      end
   end

   // ***************************************************************
   // display timing
   // ***************************************************************

   // internal syncs are active high; in enable-only mode the syncs are
   // parked at their inactive level so the panel times on enable alone
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_sync_ff <= '0;
      end else begin
         o_sync_ff.hsync <= (display_ff[`DSR_DT_SYNC_MODE] && i_sync.hsync) ^
            display_ff[`DSR_DT_HS_LOW];
         o_sync_ff.vsync <= (display_ff[`DSR_DT_SYNC_MODE] && i_sync.vsync) ^
            display_ff[`DSR_DT_VS_LOW];
         o_sync_ff.pixel_valid <= i_sync.pixel_valid ^
            display_ff[`DSR_DT_PV_LOW];
      end
   end

   // dither enables; the high variants are stored inverted
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_dither_ff <= '0;
      end else begin
         o_dither_ff.dither_stage_one_on <= display_ff[`DSR_DT_DITH1_ON];
         o_dither_ff.dither_stage_two_on <= display_ff[`DSR_DT_DITH2_ON];
         o_dither_ff.high_dither_one_on <= !display_ff[`DSR_DT_HDITH1_OFF];
         o_dither_ff.high_dither_two_on <= !display_ff[`DSR_DT_HDITH2_OFF];
      end
   end

endmodule // dsr_cfg_bank

// [core/dsr_defines.svh]
// register offsets, reset values, field positions and timing constants
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define DSR_OFS_SCL_HIGH 8'h26
`define DSR_OFS_SCL_LOW 8'h27
`define DSR_OFS_DATAPATH 8'h28
`define DSR_OFS_DISPLAY 8'h29

// ***************************************************************
// reset values
// ***************************************************************
`define DSR_RST_SCL_HIGH 8'h83
`define DSR_RST_SCL_LOW 8'h84
`define DSR_RST_DATAPATH 8'h20
`define DSR_RST_DISPLAY 8'h00

// ***************************************************************
// datapath field positions
// ***************************************************************
`define DSR_DP_KEEP_LOCAL 7
`define DSR_DP_RSVD 6
`define DSR_DP_VIDEO_OFF 5
`define DSR_DP_DUAL_LINK 4
`define DSR_DP_ALT_AUDIO 3
`define DSR_DP_AUDIO_OFF 2
`define DSR_DP_VIDEO_28 1
`define DSR_DP_SURROUND 0

// ***************************************************************
// display timing field positions
// ***************************************************************
`define DSR_DT_SYNC_MODE 7
`define DSR_DT_HS_LOW 6
`define DSR_DT_VS_LOW 5
`define DSR_DT_PV_LOW 4
`define DSR_DT_DITH2_ON 3
`define DSR_DT_DITH1_ON 2
`define DSR_DT_HDITH2_OFF 1
`define DSR_DT_HDITH1_OFF 0

// ***************************************************************
// timing: one count step of the clock period fields and the clock period; input mode codes
// ***************************************************************
`define DSR_STEP_NS 7'd50
`define DSR_CLK_NS 7'd40
`define DSR_MODE_AUTO 2'h0
`define DSR_MODE_DUAL 2'h1

`endif

// [core/dsr_pkg.sv]
// shared types and helpers of the deserializer configuration bank
package dsr_pkg;

   // clock generator phases
   typedef enum logic [1:0] {SCL_IDLE, SCL_HIGH, SCL_LOW} dsr_scl_st_t;

   // slave setup wait phases
   typedef enum logic {STR_IDLE, STR_WAIT} dsr_str_st_t;

   // datapath controls as seen by the rest of the chip
   typedef struct packed {
      logic keep_local_datapath_settings;
      logic video_off;
      logic dual_link;
      logic audio_on_gpio;
      logic audio_on;
      logic video_28bit;
      logic surround_on;
   } dsr_dp_cfg_t;

   // display sync group
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic pixel_valid;
   } dsr_sync_t;

   // dither controls, all active high
   typedef struct packed {
      logic dither_stage_one_on;
      logic dither_stage_two_on;
      logic high_dither_one_on;
      logic high_dither_two_on;
   } dsr_dither_t;

   // a period field of zero still lasts one step
   function automatic logic [7:0] dsr_at_least_one(input logic [7:0] v);
      dsr_at_least_one = (v == 8'h00) ? 8'h01 : v;
   endfunction

endpackage

// [core/dsr_scl_gen.sv]
// master clock generator: high and low phases counted in steps
module dsr_scl_gen
   import dsr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_run,
   input wire logic i_step,
   input wire logic [7:0] i_high_steps,
   input wire logic [7:0] i_low_steps,
   output logic o_scl_low_ff
);
   dsr_scl_st_t st_ff;
   logic [7:0] cnt_ff;

   // phase sequencer; a new period value takes effect at the next phase
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_run) begin
         st_ff <= SCL_IDLE;
         cnt_ff <= 8'h00;
      end else begin
         unique case (st_ff)
            SCL_IDLE: begin
               st_ff <= SCL_HIGH;
               cnt_ff <= dsr_at_least_one(i_high_steps);
            end
            SCL_HIGH: if (i_step) begin
               if (cnt_ff <= 8'h01) begin
                  st_ff <= SCL_LOW;
                  cnt_ff <= dsr_at_least_one(i_low_steps);
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            SCL_LOW: if (i_step) begin
               if (cnt_ff <= 8'h01) begin
                  st_ff <= SCL_HIGH;
                  cnt_ff <= dsr_at_least_one(i_high_steps);
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
         endcase
      end
   end

   // line is pulled low only in the low phase
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_scl_low_ff <= 1'b0;
      end else begin
         o_scl_low_ff <= i_run && (st_ff == SCL_LOW);
      end
   end
endmodule // dsr_scl_gen

// [core/dsr_setup_wait.sv]
// slave data setup wait: holds the clock low a low-period after data
module dsr_setup_wait
   import dsr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_data_presented,
   input wire logic i_step,
   input wire logic [7:0] i_low_steps,
   output logic o_hold_ff
);
   dsr_str_st_t st_ff;
   logic [7:0] cnt_ff;

   // count the setup time, then let the clock line go
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_ff <= STR_IDLE;
         cnt_ff <= 8'h00;
         o_hold_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            STR_IDLE: if (i_data_presented) begin
               st_ff <= STR_WAIT;
               cnt_ff <= dsr_at_least_one(i_low_steps);
               o_hold_ff <= 1'b1;
            end
            STR_WAIT: if (i_step) begin
               if (cnt_ff <= 8'h01) begin
                  st_ff <= STR_IDLE;
                  o_hold_ff <= 1'b0;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
         endcase
      end
   end
endmodule // dsr_setup_wait

// [test/dsr_cfg_bank_chk.sv]
// checker: read port, derived controls and slave hold relations
module dsr_cfg_bank_chk
   import dsr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] o_rd_data_ff,
   input wire logic i_fc_load,
   input wire logic i_link_up,
   input wire logic i_slv_data_presented,
   input wire logic o_slv_scl_oe_ff,
   input wire dsr_dp_cfg_t o_dp_cfg_ff,
   input wire dsr_dither_t o_dither_ff,
   input wire logic o_audio_out_en_ff,
   input wire logic o_surround_en_ff,
   input wire logic o_ctl_chan_en_ff,
   input wire logic i_mst_scl_pin,
   input wire logic o_mst_scl_seen_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // relations
   // ****************
   // one clock domain, so one clocking and one reset for all
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   property p_rd_idle;
      !i_rd_en |=> o_rd_data_ff == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_rsvd;
      i_rd_en && i_addr == 8'h28 |=> !o_rd_data_ff[6];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_ctl;
      1'b1 |=> o_ctl_chan_en_ff == $past(i_link_up);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control channel enable wrong");
   property p_audio;
      o_audio_out_en_ff == o_dp_cfg_ff.audio_on;
   endproperty
   a_audio: assert property (p_audio) else $error("audio enable wrong");
   property p_surr;
      o_surround_en_ff == (o_dp_cfg_ff.surround_on & o_dp_cfg_ff.audio_on);
   endproperty
   a_surr: assert property (p_surr) else $error("surround enable wrong");
   property p_dith;
      i_wr_en && i_addr == 8'h29 |-> ##2 o_dither_ff == {$past(i_wr_data[2], 2),
         $past(i_wr_data[3], 2), !$past(i_wr_data[0], 2), !$past(i_wr_data[1], 2)};
   endproperty
   a_dith: assert property (p_dith) else $error("dither controls wrong");
   // a refused load leaves the whole datapath group untouched
   property p_keep;
      o_dp_cfg_ff.keep_local_datapath_settings && i_fc_load && !i_wr_en && !$past(i_wr_en)
         |-> ##2 $stable(o_dp_cfg_ff);
   endproperty
   a_keep: assert property (p_keep) else $error("load not refused");
   // the hold may end one step after it starts, so only the first held cycle is certain
   property p_slv;
      i_slv_data_presented && !o_slv_scl_oe_ff && !$past(i_slv_data_presented)
         |-> ##2 o_slv_scl_oe_ff;
   endproperty
   a_slv: assert property (p_slv) else $error("slave clock not held");
   // pin view lags the pin by two sync stages and one output register
   property p_seen;
      o_mst_scl_seen_ff == $past(i_mst_scl_pin, 3);
   endproperty
   a_seen: assert property (p_seen) else $error("clock pin view wrong");
endmodule // dsr_cfg_bank_chk

// [test/dsr_ser_model.sv]
// serializer model: forward channel datapath settings loads
module dsr_ser_model (
   input wire logic i_mclk,
   output logic o_load,
   output logic [7:0] o_cfg
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle at time zero
   initial begin
      o_load = 1'b0;
      o_cfg = 8'h00;
   end
   // one load pulse; the idle bus then shows the inverse so stale data never passes
   task automatic send(input logic [7:0] v);
      @(posedge i_mclk);
      o_load <= 1'b1;
      o_cfg <= v;
      @(posedge i_mclk);
      o_load <= 1'b0;
      o_cfg <= ~v;
   endtask
endmodule // dsr_ser_model

// [test/tb.sv]
// testbench: registers, derived controls, clock phases and forward loads
module tb
   import dsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // signals and instances
   // ****************
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic i_link_up = 1'b0;
   logic i_lock_mode = 1'b0;
   logic [1:0] i_input_mode = 2'h0;
   logic i_mst_run = 1'b0;
   logic i_slv_stretch_req = 1'b0;
   logic i_slv_data_presented = 1'b0;
   dsr_sync_t i_sync = '0;
   logic i_fc_load, o_rx_lock_ff, o_rx_dual_ff, o_mst_scl_o_ff, o_mst_scl_oe_ff;
   logic o_mst_scl_seen_ff, o_slv_scl_o_ff, o_slv_scl_oe_ff, o_audio_out_en_ff;
   logic o_surround_en_ff, o_gpio1_word_clk_sel_ff, o_gpio0_audio_data_sel_ff;
   logic o_ctl_chan_en_ff;
   logic [7:0] i_fc_cfg, o_rd_data_ff, v, w, u;
   dsr_dp_cfg_t o_dp_cfg_ff;
   dsr_sync_t o_sync_ff;
   dsr_dither_t o_dither_ff;
   logic [2:0] s;
   logic [7:0] rd_q[$];
   logic rd_dly = 1'b0;
   logic osel = 1'b0;
   int err_total = 0;
   int checks_done = 0;
   int n;
   // pull-up on the master clock pin
   wire i_mst_scl_pin = !o_mst_scl_oe_ff;
   wire pick = osel ? o_slv_scl_oe_ff : o_mst_scl_oe_ff;
   dsr_cfg_bank dsr_cfg_bank_inst (.i_mclk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_en,
      .i_rd_en, .o_rd_data_ff, .i_fc_load, .i_fc_cfg, .i_link_up, .i_lock_mode, .i_input_mode,
      .o_rx_lock_ff, .o_rx_dual_ff, .i_mst_run, .i_mst_scl_pin, .o_mst_scl_o_ff,
      .o_mst_scl_oe_ff, .o_mst_scl_seen_ff, .i_slv_stretch_req, .i_slv_data_presented,
      .o_slv_scl_o_ff, .o_slv_scl_oe_ff, .o_dp_cfg_ff, .i_sync, .o_sync_ff, .o_dither_ff,
      .o_audio_out_en_ff, .o_surround_en_ff, .o_gpio1_word_clk_sel_ff,
      .o_gpio0_audio_data_sel_ff, .o_ctl_chan_en_ff);
   dsr_ser_model dsr_ser_model_inst (.i_mclk, .o_load(i_fc_load), .o_cfg(i_fc_cfg));
   // 25 MHz clock
   always #20 i_mclk = ~i_mclk;
   // ****************
   // tasks
   // ****************
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, e, g);
      end
   endtask
   // phase lengths may land one cycle either way of the 1.25-cycle step average
   task automatic cmp_len(input string nm, input int e, input int g);
      checks_done++;
      if (g < e - 1 || g > e + 1) begin
         err_total++;
         $display("mismatch %s exp %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_mclk);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      rd_q.push_back(e);
      @(posedge i_mclk);
      i_rd_en <= 1'b0;
   endtask
   // counts the edges for which the watched clock enable stays at lvl
   task automatic run_len(input logic lvl, output int len);
      len = 0;
      for (int t = 0; t < 400 && pick !== lvl; t++) begin
         @(posedge i_mclk);
      end
      while (len < 400 && pick === lvl) begin
         @(posedge i_mclk);
         len++;
      end
      if (len == 0 || len == 400) begin
         err_total++;
         $display("mismatch phase exp bounded seen %0d", len);
         close_out();
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge i_mclk) begin
      if (rd_dly) cmp("read", rd_q.pop_front(), o_rd_data_ff);
      rd_dly <= i_rd_en;
   end
   // ****************
   // scenarios
   // ****************
   initial begin
      n = $urandom(7691);
      repeat (5) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      rd(8'h26, 8'h83);
      rd(8'h27, 8'h84);
      rd(8'h28, 8'h20);
      rd(8'h29, 8'h00);
      rd(8'h2b, 8'h00);
      // default phases: 132 and 131 steps
      i_mst_run <= 1'b1;
      run_len(1'b1, n);
      cmp_len("scl low", 165, n);
      run_len(1'b0, n);
      cmp_len("scl high", 164, n);
      for (int k = 0; k < 16; k++) begin
         v = 8'($urandom);
         w = 8'($urandom);
         s = 3'($urandom);
         {i_link_up, i_lock_mode, i_input_mode} <= 4'($urandom);
         i_sync <= s;
         wr(8'h28, v);
         wr(8'h29, w);
         repeat (2) @(posedge i_mclk);
         #1;
         cmp("dp_cfg", {1'b0, v[7], v[5:3], ~v[2], v[1:0]}, {1'b0, o_dp_cfg_ff});
         cmp("dither", {4'h0, w[2], w[3], ~w[0], ~w[1]}, {4'h0, o_dither_ff});
         u = {5'h0, (w[7] & s[2]) ^ w[6], (w[7] & s[1]) ^ w[5], s[0] ^ w[4]};
         cmp("sync", u, {5'h0, o_sync_ff});
         u = {7'h0, i_link_up & (i_lock_mode | ~v[5])};
         cmp("lock", u, {7'h0, o_rx_lock_ff});
         u = {7'h0, (i_input_mode == 2'h0) ? v[4] : (i_input_mode == 2'h1)};
         cmp("dual", u, {7'h0, o_rx_dual_ff});
         u = {4'h0, o_audio_out_en_ff, o_surround_en_ff, o_gpio1_word_clk_sel_ff,
            o_gpio0_audio_data_sel_ff};
         cmp("audio", {4'h0, ~v[2], v[0] & ~v[2], v[3], v[3]}, u);
         cmp("open drain", 8'h00, {6'h0, o_mst_scl_o_ff, o_slv_scl_o_ff});
         rd(8'h28, v & 8'hbf);
         rd(8'h29, w);
      end
      // forward loads, every other one refused by the keep-local bit
      for (int k = 0; k < 4; k++) begin
         u = 8'($urandom);
         wr(8'h28, {k[0], 7'h00});
         dsr_ser_model_inst.send(u);
         rd(8'h28, k[0] ? 8'h80 : {2'b00, u[5:0]});
      end
      // short phases: the first phase seen may still use the old counts
      wr(8'h26, 8'h08);
      wr(8'h27, 8'h04);
      run_len(1'b1, n);
      run_len(1'b0, n);
      cmp_len("scl high", 10, n);
      run_len(1'b1, n);
      cmp_len("scl low", 5, n);
      osel = 1'b1;
      @(posedge i_mclk);
      i_slv_data_presented <= 1'b1;
      @(posedge i_mclk);
      i_slv_data_presented <= 1'b0;
      run_len(1'b1, n);
      cmp_len("slave hold", 5, n);
      repeat (3) @(posedge i_mclk);
      close_out();
   end
endmodule // tb

bind dsr_cfg_bank dsr_cfg_bank_chk dsr_cfg_bank_chk_inst (.i_mclk, .i_sys_rst, .i_addr,
   .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data_ff, .i_fc_load, .i_link_up,
   .i_slv_data_presented, .o_slv_scl_oe_ff, .o_dp_cfg_ff, .o_dither_ff, .o_audio_out_en_ff,
   .o_surround_en_ff, .o_ctl_chan_en_ff, .i_mst_scl_pin, .o_mst_scl_seen_ff);
